// ### hw/table_xfer_pkg.sv
// Shared constants and types for the table transfer and reset flag block.
package table_xfer_pkg;
  localparam int BYTE_W = 8;
  localparam int REG_AW = 3;
  localparam int PTR_W_DEF = 21;
  localparam int INT_AW_DEF = 15;
  // Register offsets on the plain register port.
  localparam logic [REG_AW-1:0] REG_RCS = 3'h0;
  localparam logic [REG_AW-1:0] REG_LATCH = 3'h1;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h2;
  localparam logic [REG_AW-1:0] REG_MASK = 3'h3;
  // Field positions inside reset_control_status.
  localparam int LWE_BIT = 6;
  localparam int POR_BIT = 1;
  localparam int BOR_BIT = 0;
  // Event bits of the interrupt status and mask registers.
  localparam int EVT_W = 4;
  localparam int ST_READ_DONE = 0;
  localparam int ST_WRITE_DONE = 1;
  localparam int ST_WRITE_BLOCKED = 2;
  localparam int ST_BROWN_OUT = 3;
  // Reset values.
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [EVT_W-1:0] EVT_NONE = 4'h0;
  typedef enum logic [1:0] {XF_IDLE, XF_ACCESS, XF_FINISH} xfer_state_e;
endpackage

// ### hw/prog_mem_if.sv
// Byte port between the transfer controller and internal program memory.
`timescale 1ns/100ps
interface prog_mem_if #(parameter int AW = 15);
  logic req;
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl(output req, output we, output addr, output wdata, input rdata);
  modport mem(input req, input we, input addr, input wdata, output rdata);
endinterface

// ### hw/prog_mem_store.sv
// Internal byte-addressed program memory, read data one cycle after the request.
`timescale 1ns/100ps
module prog_mem_store
  import table_xfer_pkg::*;
#(
  parameter int AW = INT_AW_DEF
) (
  input wire logic clk,
  prog_mem_if.mem port
);
  logic [BYTE_W-1:0] cells [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////////
  // Memory has no reset; software must not rely on its power-up contents.
  always_ff @(posedge clk) begin
    if (port.req && port.we) begin
      cells[port.addr] <= port.wdata;
    end
    if (port.req && !port.we) begin
      port.rdata <= cells[port.addr];
    end
  end
endmodule

// ### hw/reset_status_flags.sv
// Long-write enable and power-on and brown-out status flags.
`timescale 1ns/100ps
module reset_status_flags
  import table_xfer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic master_clear_pin,
  input wire logic brown_lvl,
  input wire logic wr,
  input wire logic [BYTE_W-1:0] wdata,
  output logic lwe,
  output logic por_flag,
  output logic bor_flag
);
  logic next_lwe;
  logic next_por;
  logic next_bor;

  ////////////////////////////////////////////////////////////////////////////
  // Software can only set the enable; a zero written is ignored on purpose.
  assign next_lwe = master_clear_pin ? 1'b0 : (lwe | (wr & wdata[LWE_BIT]));
  assign next_por = wr ? wdata[POR_BIT] : por_flag;
  // A brown-out held high beats any software write in the same cycle.
  assign next_bor = brown_lvl ? 1'b0 : (wr ? wdata[BOR_BIT] : bor_flag);

  // Power-on reset clears all three.
  always_ff @(posedge clk) begin
    if (rst) begin
      lwe <= 1'b0;
      por_flag <= 1'b0;
      bor_flag <= 1'b0;
    end else begin
      lwe <= next_lwe;
      por_flag <= next_por;
      bor_flag <= next_bor;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_lwe_sticky: assert property (lwe && !master_clear_pin |=> lwe)
    else $error("long write enable dropped without master clear");
  a_bor_priority: assert property (brown_lvl && wr |=> !bor_flag)
    else $error("brown-out flag not cleared under simultaneous write");
  a_por_after_reset: assert property ($past(rst) |-> !por_flag && !lwe)
    else $error("power-on flag or enable not clear after power-on reset");
  a_por_sw_set: assert property (wr && wdata[POR_BIT] |=> por_flag)
    else $error("software could not set power-on flag");
endmodule

// ### hw/table_transfer_reset_flags.sv
// Table transfer controller with holding latch, reset status flags and register port.
// Functional notes
// - Program and data spaces exchange bytes only through the 8-bit holding latch.
// - A table read fetches a program byte into the holding latch.
// - A table write stores the holding latch byte into program memory.
// - Transfers are single bytes at any byte address, no alignment.
// - Enable set and programming voltage present permit internal writes, code keeps running.
// - Long-write enable, once set, clears only on power-on or master-clear reset.
// - Power-on reset clears the power-on flag; software sets it again.
// - Brown-out clears the brown-out flag, otherwise it holds the value software last wrote to it.
// - Enable clear blocks internal table writes; external writes still go through.
// - Long-write enable is bit 6 of reset_control_status and resets to zero.
`timescale 1ns/100ps
module table_transfer_reset_flags
  import table_xfer_pkg::*;
#(
  parameter int PTR_W = PTR_W_DEF,
  parameter int INT_AW = INT_AW_DEF
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic BROWN_OUT_RESET,
  input wire logic MASTER_CLEAR_PIN,
  input wire logic MASTER_CLEAR_VPP,
  input wire logic [REG_AW-1:0] REG_ADDR,
  input wire logic [BYTE_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [BYTE_W-1:0] REG_RDATA,
  input wire logic PROGRAM_TO_DATA_READ_OP,
  input wire logic DATA_TO_PROGRAM_WRITE_OP,
  input wire logic [PTR_W-1:0] PROGRAM_BYTE_POINTER,
  output logic BUSY,
  output logic OP_DONE,
  output logic WRITE_BLOCKED,
  output logic [PTR_W-1:0] EXT_ADDR,
  output logic [BYTE_W-1:0] EXT_WDATA,
  output logic EXT_WE,
  output logic EXT_RE,
  input wire logic [BYTE_W-1:0] EXT_RDATA,
  output logic IRQ
);
  localparam int NPIN = 3;

  xfer_state_e state;
  xfer_state_e next_state;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_sync;
  logic brown_lvl;
  logic master_clear_pin;
  logic vpp;
  logic brown_seen;
  logic brown_evt;
  logic lwe;
  logic por_flag;
  logic bor_flag;
  logic [BYTE_W-1:0] transfer_holding_latch;
  logic [BYTE_W-1:0] next_latch;
  logic [PTR_W-1:0] ptr_q;
  logic op_write;
  logic op_int;
  logic op_blocked;
  logic take_op;
  logic take_int;
  logic take_allowed;
  logic [BYTE_W-1:0] read_byte;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] w1c;
  logic wr_rcs;
  logic wr_latch;
  logic wr_status;
  logic wr_mask;
  logic [BYTE_W-1:0] rcs_view;
  logic [BYTE_W-1:0] read_mux;

  prog_mem_if #(.AW(INT_AW)) pm();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  assign pin_raw = {MASTER_CLEAR_VPP, MASTER_CLEAR_PIN, BROWN_OUT_RESET};
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    logic stage_a;
    logic stage_b;
    always_ff @(posedge SYS_CLK) begin
      if (RST) begin
        stage_a <= 1'b0;
        stage_b <= 1'b0;
      end else begin
        stage_a <= pin_raw[i];
        stage_b <= stage_a;
      end
    end
    assign pin_sync[i] = stage_b;
  end
  assign brown_lvl = pin_sync[0];
  assign master_clear_pin = pin_sync[1];
  assign vpp = pin_sync[2];
  assign brown_evt = brown_lvl & ~brown_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  assign wr_rcs = REG_WR && (REG_ADDR == REG_RCS);
  assign wr_latch = REG_WR && (REG_ADDR == REG_LATCH);
  assign wr_status = REG_WR && (REG_ADDR == REG_STATUS);
  assign wr_mask = REG_WR && (REG_ADDR == REG_MASK);

  // Flag storage; master clear reaches only the enable bit.
  reset_status_flags u_flags (
    .clk(SYS_CLK),
    .rst(RST),
    .master_clear_pin(master_clear_pin),
    .brown_lvl(brown_lvl),
    .wr(wr_rcs),
    .wdata(REG_WDATA),
    .lwe(lwe),
    .por_flag(por_flag),
    .bor_flag(bor_flag)
  );

  // Unimplemented bits of reset_control_status read as zero.
  assign rcs_view = (BYTE_W'(lwe) << LWE_BIT) | (BYTE_W'(por_flag) << POR_BIT)
    | (BYTE_W'(bor_flag) << BOR_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // Op acceptance; addresses below the internal size hit internal memory.
  assign take_op = (state == XF_IDLE) && !master_clear_pin
    && (PROGRAM_TO_DATA_READ_OP || DATA_TO_PROGRAM_WRITE_OP);
  // No alignment check: any byte address is taken as is.
  assign take_int = (PROGRAM_BYTE_POINTER[PTR_W-1:INT_AW] == '0);
  // Internal writes need both the enable bit and the programming voltage.
  assign take_allowed = !take_int || (lwe && vpp);

  // Reads beat writes if the core raises both; the core should not.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ptr_q <= '0;
      op_write <= 1'b0;
      op_int <= 1'b0;
      op_blocked <= 1'b0;
    end else if (take_op) begin
      ptr_q <= PROGRAM_BYTE_POINTER;
      op_write <= !PROGRAM_TO_DATA_READ_OP;
      op_int <= take_int;
      op_blocked <= !PROGRAM_TO_DATA_READ_OP && !take_allowed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: take, access, finish; the core is never stalled.
  always_comb begin
    next_state = state;
    case (state)
      XF_IDLE: begin
        if (take_op) begin
          next_state = XF_ACCESS;
        end
      end
      XF_ACCESS: begin
        next_state = XF_FINISH;
      end
      XF_FINISH: begin
        next_state = XF_IDLE;
      end
      default: begin
        next_state = XF_IDLE;
      end
    endcase
  end

  // Master clear abandons any transfer in flight.
  always_ff @(posedge SYS_CLK) begin
    if (RST || master_clear_pin) begin
      state <= XF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory strobes; the written byte is always the holding latch.
  assign pm.req = (state == XF_ACCESS) && op_int && !op_blocked;
  assign pm.we = op_write;
  assign pm.addr = ptr_q[INT_AW-1:0];
  assign pm.wdata = transfer_holding_latch;
  assign EXT_WE = (state == XF_ACCESS) && !op_int && op_write;
  assign EXT_RE = (state == XF_ACCESS) && !op_int && !op_write;
  assign EXT_ADDR = ptr_q;
  assign EXT_WDATA = transfer_holding_latch;

  prog_mem_store #(.AW(INT_AW)) u_mem (
    .clk(SYS_CLK),
    .port(pm.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Holding latch: a finishing table read wins over a software write.
  assign read_byte = op_int ? pm.rdata : EXT_RDATA;
  assign next_latch = (state == XF_FINISH && !op_write) ? read_byte
    : (wr_latch ? REG_WDATA : transfer_holding_latch);

  always_ff @(posedge SYS_CLK) begin
    if (RST || master_clear_pin) begin
      transfer_holding_latch <= BYTE_ZERO;
    end else begin
      transfer_holding_latch <= next_latch;
    end
  end

  assign BUSY = (state != XF_IDLE);
  assign OP_DONE = (state == XF_FINISH);
  assign WRITE_BLOCKED = (state == XF_FINISH) && op_blocked;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: write one to clear, a new event in the same cycle wins.
  assign events[ST_READ_DONE] = OP_DONE && !op_write;
  assign events[ST_WRITE_DONE] = OP_DONE && op_write && !op_blocked;
  assign events[ST_WRITE_BLOCKED] = WRITE_BLOCKED;
  assign events[ST_BROWN_OUT] = brown_evt;
  assign w1c = wr_status ? REG_WDATA[EVT_W-1:0] : EVT_NONE;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      status <= EVT_NONE;
      mask <= EVT_NONE;
      brown_seen <= 1'b0;
    end else begin
      status <= (status & ~w1c) | events;
      mask <= wr_mask ? REG_WDATA[EVT_W-1:0] : mask;
      brown_seen <= brown_lvl;
    end
  end

  assign IRQ = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the read strobe.
  assign read_mux = (REG_ADDR == REG_RCS) ? rcs_view
    : (REG_ADDR == REG_LATCH) ? transfer_holding_latch
    : (REG_ADDR == REG_STATUS) ? BYTE_W'(status)
    : (REG_ADDR == REG_MASK) ? BYTE_W'(mask) : BYTE_ZERO;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REG_RDATA <= BYTE_ZERO;
    end else begin
      REG_RDATA <= REG_RD ? read_mux : BYTE_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the transfer path and register port.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST || master_clear_pin);

  sequence s_read_taken;
    take_op && PROGRAM_TO_DATA_READ_OP;
  endsequence

  sequence s_write_taken;
    take_op && !PROGRAM_TO_DATA_READ_OP;
  endsequence

  sequence s_int_write_ok;
    s_write_taken ##0 take_int && lwe && vpp;
  endsequence

  a_read_loads_latch: assert property (
    s_read_taken ##2 (OP_DONE && !master_clear_pin) |=> transfer_holding_latch == $past(read_byte))
    else $error("table read did not load the holding latch");

  a_write_uses_latch: assert property (
    (pm.req && pm.we) || EXT_WE |-> pm.wdata == transfer_holding_latch
      && EXT_WDATA == transfer_holding_latch)
    else $error("table write data not taken from the holding latch");

  a_latch_only_path: assert property (
    transfer_holding_latch != $past(transfer_holding_latch)
      |-> $past(OP_DONE && !op_write) || $past(wr_latch) || $past(RST || master_clear_pin))
    else $error("holding latch changed outside a table read or register write");

  a_any_byte_addr: assert property (
    take_op |=> EXT_ADDR == $past(PROGRAM_BYTE_POINTER))
    else $error("pointer altered or aligned on capture");

  a_long_write_ok: assert property (
    s_int_write_ok |=> pm.req && pm.we ##1 OP_DONE && !WRITE_BLOCKED)
    else $error("enabled internal write did not reach program memory");

  a_internal_guard: assert property (
    s_write_taken ##0 take_int && !(lwe && vpp) |=> !pm.req ##1 WRITE_BLOCKED)
    else $error("internal write not blocked without enable");

  a_ext_write_free: assert property (
    s_write_taken ##0 !take_int |=> EXT_WE && !pm.req ##1 OP_DONE && !WRITE_BLOCKED)
    else $error("external write was blocked");

  a_lwe_readback: assert property (
    REG_RD && REG_ADDR == REG_RCS |=> REG_RDATA[LWE_BIT] == $past(lwe)
      && REG_RDATA[BYTE_W-3] == 1'b0)
    else $error("enable bit not at its field position on readback");

  a_bor_flag_clear: assert property (
    brown_lvl |=> !bor_flag)
    else $error("brown-out did not clear its flag");

  a_brown_event: assert property (
    brown_evt |=> status[ST_BROWN_OUT])
    else $error("brown-out did not raise its status event");

  a_flag_write_now: assert property (
    wr_rcs && !brown_lvl |=> por_flag == $past(REG_WDATA[POR_BIT])
      && bor_flag == $past(REG_WDATA[BOR_BIT]))
    else $error("software flag write not applied at the next edge");

  a_op_spacing: assert property (
    take_op |=> BUSY [*2] ##1 !BUSY)
    else $error("transfer did not take exactly three cycles");
endmodule

// ### tb/ext_prog_mem_model.sv
// Behavioural external program memory that answers the block's byte strobes.
`timescale 1ns/100ps
module ext_prog_mem_model
  import table_xfer_pkg::*;
(
  input wire logic clk,
  input wire logic [PTR_W_DEF-1:0] addr,
  input wire logic [BYTE_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [BYTE_W-1:0] rdata
);
  logic [BYTE_W-1:0] mem [0:255];
  // Known pattern so a read of an untouched byte has a predictable value.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    rdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // Byte writes land at address bits 7:0 only, and the read byte stands only in the cycle after
  // the strobe; otherwise the line toggles so a late sample cannot pass by luck.
  always @(posedge clk) begin
    if (we) begin
      mem[addr[7:0]] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr[7:0]];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule

// ### tb/test_table_transfer_reset_flags.sv
// Self-checking testbench for the table transfer and reset flag block.
`timescale 1ns/100ps
module test_table_transfer_reset_flags
  import table_xfer_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic brown = 1'b0, master_clear_pin = 1'b0, vpp = 1'b0;
  logic [REG_AW-1:0] reg_addr = 3'h0;
  logic [BYTE_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_op = 1'b0, wr_op = 1'b0;
  logic [PTR_W_DEF-1:0] ptr = 21'h00_0000;
  logic [BYTE_W-1:0] reg_rdata, ext_wdata, ext_rdata, rv;
  logic [PTR_W_DEF-1:0] ext_addr;
  logic busy, op_done, write_blocked, ext_we, ext_re, irq;
  int err_count = 0;
  int compares = 0;
  always #25 sys_clk = ~sys_clk;
  // Small internal space keeps the address split easy to cross.
  localparam int sim_int_aw = 6;
  table_transfer_reset_flags #(.PTR_W(PTR_W_DEF), .INT_AW(sim_int_aw)) i_table_transfer_reset_flags (
    .SYS_CLK(sys_clk), .RST(rst), .BROWN_OUT_RESET(brown), .MASTER_CLEAR_PIN(master_clear_pin),
    .MASTER_CLEAR_VPP(vpp), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PROGRAM_TO_DATA_READ_OP(rd_op),
    .DATA_TO_PROGRAM_WRITE_OP(wr_op), .PROGRAM_BYTE_POINTER(ptr), .BUSY(busy),
    .OP_DONE(op_done), .WRITE_BLOCKED(write_blocked), .EXT_ADDR(ext_addr),
    .EXT_WDATA(ext_wdata), .EXT_WE(ext_we), .EXT_RE(ext_re), .EXT_RDATA(ext_rdata),
    .IRQ(irq));
  ext_prog_mem_model i_ext_prog_mem_model (
    .clk(sys_clk), .addr(ext_addr), .wdata(ext_wdata), .we(ext_we), .re(ext_re),
    .rdata(ext_rdata));
  ////////////////////////////////////////////////////////////////////////
  // Shared compare, bus cycles and transfer request.
  task automatic check(input logic [BYTE_W-1:0] seen, input logic [BYTE_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [BYTE_W-1:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data are sampled in the one cycle where they stand.
  task automatic rd(input logic [REG_AW-1:0] a, output logic [BYTE_W-1:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic op(input logic is_rd, input logic [PTR_W_DEF-1:0] p, input logic blk);
    logic ext;
    ext = (p >> sim_int_aw) != '0;
    @(posedge sys_clk);
    rd_op <= is_rd;
    wr_op <= ~is_rd;
    ptr <= p;
    @(posedge sys_clk);
    rd_op <= 1'b0;
    wr_op <= 1'b0;
    // External strobes stand only in the access cycle.
    #1 check({6'h00, ext_we, ext_re}, {6'h00, ext && !is_rd, ext && is_rd});
    @(posedge sys_clk);
    #1 check({7'h00, op_done}, 8'h01);
    check({7'h00, busy}, 8'h01);
    check({7'h00, write_blocked}, {7'h00, blk});
    check(ext_addr[7:0], p[7:0]);
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_vals();
    rd(REG_RCS, rv);
    check(rv, 8'h00);
    rd(3'h5, rv);
    check(rv, 8'h00);
    wr(REG_RCS, 8'h03);
    rd(REG_RCS, rv);
    check(rv, 8'h03);
  endtask
  // External bytes at odd addresses go out and come back through the latch.
  task automatic t_external();
    wr(REG_LATCH, 8'hA5);
    op(1'b0, 21'h00_0043, 1'b0);
    op(1'b1, 21'h00_0044, 1'b0);
    rd(REG_LATCH, rv);
    check(rv, 8'h44 ^ 8'h5A);
    op(1'b1, 21'h00_0043, 1'b0);
    rd(REG_LATCH, rv);
    check(rv, 8'hA5);
  endtask
  task automatic t_blocked();
    wr(REG_STATUS, 8'hFF);
    wr(REG_MASK, 8'h04);
    op(1'b0, 21'h00_0006, 1'b1);
    rd(REG_STATUS, rv);
    check(rv, 8'h04);
    check({7'h00, irq}, 8'h01);
    wr(REG_STATUS, 8'h04);
    #1 check({7'h00, irq}, 8'h00);
  endtask
  // Word-aligned instruction byte written internally once both gates are open.
  task automatic t_long_write();
    @(posedge sys_clk);
    vpp <= 1'b1;
    wr(REG_RCS, 8'h43);
    ticks(4);
    rd(REG_RCS, rv);
    check(rv, 8'h43);
    wr(REG_LATCH, 8'h3C);
    op(1'b0, 21'h00_0006, 1'b0);
    wr(REG_LATCH, 8'h00);
    op(1'b1, 21'h00_0006, 1'b0);
    rd(REG_LATCH, rv);
    check(rv, 8'h3C);
    wr(REG_RCS, 8'h00);
    rd(REG_RCS, rv);
    check(rv, 8'h40);
    @(posedge sys_clk);
    vpp <= 1'b0;
    ticks(4);
    op(1'b0, 21'h00_0007, 1'b1);
    master_clear_pin <= 1'b1;
    ticks(4);
    master_clear_pin <= 1'b0;
    ticks(4);
    rd(REG_RCS, rv);
    check(rv, 8'h00);
  endtask
  // A software set of the brown-out flag while the brown-out stands must lose to it.
  task automatic t_brown_out();
    wr(REG_RCS, 8'h03);
    wr(REG_STATUS, 8'hFF);
    wr(REG_MASK, 8'h08);
    brown <= 1'b1;
    ticks(4);
    rd(REG_RCS, rv);
    check(rv, 8'h02);
    check({7'h00, irq}, 8'h01);
    wr(REG_RCS, 8'h03);
    rd(REG_RCS, rv);
    check(rv, 8'h02);
    @(posedge sys_clk);
    brown <= 1'b0;
    ticks(4);
    wr(REG_RCS, 8'h03);
    rd(REG_RCS, rv);
    check(rv, 8'h03);
  endtask
  // A second power-on in mid-run clears both flags; software then marks it seen.
  task automatic t_power_on();
    @(posedge sys_clk);
    rst <= 1'b1;
    ticks(2);
    rst <= 1'b0;
    rd(REG_RCS, rv);
    check(rv, 8'h00);
    check({7'h00, irq}, 8'h00);
    wr(REG_RCS, 8'h02);
    rd(REG_RCS, rv);
    check(rv, 8'h02);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict, watchdog and main sequence.
  task automatic wrap_up();
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    ticks(3000);
    err_count++;
    wrap_up();
  end
  initial begin
    ticks(3);
    rst <= 1'b0;
    t_reset_vals();
    t_external();
    t_blocked();
    t_long_write();
    t_brown_out();
    t_power_on();
    wrap_up();
  end
endmodule
